// >>> hdl/sdgc_irq_gen.v
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Host interrupt signalling: edge pulse or level
// ----------------------------------------------------------------
module sdgc_irq_gen (
  input  wire sys_clk,
  input  wire reset_n,
  input  wire level_mode,
  input  wire pending,
  output wire host_irq
);

  reg pending_q;
  reg pulse_q;

  // Edge mode gives one pulse per newly set cause
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pending_q <= 1'b0;
      pulse_q   <= 1'b0;
    end else begin
      pending_q <= pending;
      pulse_q   <= pending & ~pending_q;
    end
  end

  // Level mode follows the cause while it stands
  assign host_irq = level_mode ? pending_q : pulse_q;

endmodule

// >>> hdl/sdgc_sync3.v
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Three-stage pin synchroniser with agreement filter
// ----------------------------------------------------------------
module sdgc_sync3 #(
  parameter WIDTH = 1
) (
  input  wire             sys_clk,
  input  wire             reset_n,
  input  wire [WIDTH-1:0] pin_in,
  output reg  [WIDTH-1:0] level_q,
  output reg              valid_q
);

  reg [WIDTH-1:0] stage1_q;
  reg [WIDTH-1:0] stage2_q;
  reg [WIDTH-1:0] stage3_q;
  reg [1:0]       fill_q;

  // Capture chain; level moves only when stages two and three agree
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_q <= {WIDTH{1'b0}};
      stage2_q <= {WIDTH{1'b0}};
      stage3_q <= {WIDTH{1'b0}};
      level_q  <= {WIDTH{1'b0}};
      fill_q   <= 2'h0;
      valid_q  <= 1'b0;
    end else begin
      stage1_q <= pin_in;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      if (fill_q != 2'h3) begin
        fill_q <= fill_q + 2'h1;
      end
      // Level is trusted once the chain has filled
      valid_q <= (fill_q == 2'h3);
      level_q <= (stage2_q & stage3_q) | (level_q & (stage2_q | stage3_q));
    end
  end

endmodule

// >>> hdl/sdgc_top.v
`timescale 1ns/1ps
`include "sdgc_defs.vh"

// Overview of operation
// - Detect bit 7 reads the live second voltage-sense level.
// - Detect bit 6 reads the live first voltage-sense level.
// - Writing 1 to bit 5 with detect irq enabled raises a status change.
// - Writing 1 to bit 5 with detect irq disabled does nothing.
// - Bit 5 always reads back as zero.
// - With wake enabled, a card-detect change drives ring indicate low.
// - Ring indicate stays low until the detect-change status flag clears.
// - With wake disabled (reset value) detect changes leave ring indicate alone.
// - Detect register bits 3, 2 and 0 read as zero.
// - Removal-reset set makes card removal reset the socket's compatibility registers.
// - One global control register, visible at both sockets' offsets.
// - Global bits 7 to 5 read zero; writable bits reset to zero.
// - Global bit 4 picks edge or level host interrupt for socket B.
// - Global bit 3 picks edge or level host interrupt for socket A.
// - Global bit 2: status flags clear on read, or by writing 1 back.
// - Global bit 1 picks edge or level for status-change host interrupt.
// - Sleep bit floats card outputs except during an active card cycle.
// - Sleep still accepts DMA and interrupts; only card access wakes interface.
module sdgc_top (
  input  wire       sys_clk,
  input  wire       reset_n,
  // Register port
  input  wire [7:0] reg_addr,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  // Socket pins, index 0 is socket A, index 1 is socket B
  input  wire [1:0] card_detect_one,
  input  wire [1:0] card_detect_two,
  input  wire [1:0] voltage_sense_one,
  input  wire [1:0] voltage_sense_two,
  input  wire [1:0] card_func_irq,
  // Enables held in the interrupt configuration register
  input  wire [1:0] card_detect_irq_enable,
  // Card interface activity
  input  wire [1:0] card_cycle_active,
  input  wire [1:0] dma_request,
  // Outputs
  output wire       ring_indicate_output_n,
  output wire [1:0] status_change_host_irq,
  output wire [1:0] func_host_irq,
  output wire [1:0] dma_request_out,
  output wire [1:0] card_if_drive_en,
  output reg  [1:0] compat_reg_reset
);

  // ----------------------------------------------------------------
  // Shared global control storage
  // ----------------------------------------------------------------
  reg  [`SDGC_GLB_WIDTH-1:0] global_ctrl_q;

  wire socket_b_irq_level_sel      = global_ctrl_q[`SDGC_GLB_B_LEVEL];
  wire socket_a_irq_level_sel      = global_ctrl_q[`SDGC_GLB_A_LEVEL];
  wire flag_clear_method           = global_ctrl_q[`SDGC_GLB_CLEAR_METHOD];
  wire status_change_irq_level_sel = global_ctrl_q[`SDGC_GLB_SC_LEVEL];
  wire interface_sleep             = global_ctrl_q[`SDGC_GLB_SLEEP];

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire [7:0] index_addr = reg_addr & ~`SDGC_SOCKET_B_STRIDE;
  wire       sel_b      = (reg_addr & `SDGC_SOCKET_B_STRIDE) != 8'h00;
  wire       hit_status = (index_addr == `SDGC_OFS_STATUS_CHANGE);
  wire       hit_detect = (index_addr == `SDGC_OFS_DETECT_GENERAL);
  wire       hit_global = (index_addr == `SDGC_OFS_GLOBAL_CONTROL);

  wire [1:0] sock_sel   = sel_b ? 2'b10 : 2'b01;

  // Per-socket read images and wake state
  wire [15:0] detect_rd_bus;
  wire [15:0] status_rd_bus;
  wire [1:0]  wake_low;
  wire [1:0]  compat_req;

  // ----------------------------------------------------------------
  // Global control register, one copy for both sockets
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      global_ctrl_q <= `SDGC_GLB_RESET;
    end else if (reg_wr && hit_global) begin
      global_ctrl_q <= reg_wdata[`SDGC_GLB_WIDTH-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Per-socket logic
  // ----------------------------------------------------------------
  genvar s;
  generate
    for (s = 0; s < 2; s = s + 1) begin : g_sock
      wire [`SDGC_LANES-1:0] pins_sync;
      wire                   sync_valid;
      reg                    wake_en_q;
      reg                    removal_rst_q;
      reg                    detect_flag_q;
      reg                    wake_low_q;
      reg                    cd_one_prev_q;
      reg                    cd_two_prev_q;
      reg                    present_prev_q;
      reg                    primed_q;
      wire                   det_wr;
      wire                   det_rd_hit;
      wire                   sts_wr;
      wire                   sts_rd;
      wire                   cd_change;
      wire                   card_present;
      wire                   removal;
      wire                   soft_set;
      wire                   flag_set;
      wire                   flag_clr;
      wire                   func_level_sel;

      // Pin synchroniser for detect, sense and function interrupt
      sdgc_sync3 #(
        .WIDTH (`SDGC_LANES)
      ) u_sync (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .pin_in  ({card_func_irq[s], voltage_sense_two[s], voltage_sense_one[s],
                   card_detect_two[s], card_detect_one[s]}),
        .level_q (pins_sync),
        .valid_q (sync_valid)
      );

      // Strobes for this socket
      assign det_wr     = reg_wr & hit_detect & sock_sel[s];
      assign det_rd_hit = reg_rd & hit_detect & sock_sel[s];
      assign sts_wr     = reg_wr & hit_status & sock_sel[s];
      assign sts_rd     = reg_rd & hit_status & sock_sel[s];

      // Card-detect change and removal; detect pins are active low
      assign card_present = ~pins_sync[`SDGC_LANE_CD_ONE] & ~pins_sync[`SDGC_LANE_CD_TWO];
      assign cd_change    = primed_q &
                            ((pins_sync[`SDGC_LANE_CD_ONE] != cd_one_prev_q) |
                             (pins_sync[`SDGC_LANE_CD_TWO] != cd_two_prev_q));
      assign removal      = primed_q & present_prev_q & ~card_present;

      // Soft status change only while detect interrupts are enabled
      assign soft_set = det_wr & reg_wdata[`SDGC_DET_SOFT_IRQ] &
                        card_detect_irq_enable[s];

      // Flag set and clear; clear path picked by global bit 2
      assign flag_set = cd_change | soft_set;
      assign flag_clr = flag_clear_method ?
                        (sts_wr & reg_wdata[`SDGC_STS_DETECT_CHANGE]) :
                        sts_rd;

      // Edge history of detect pins
      always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          cd_one_prev_q  <= 1'b0;
          cd_two_prev_q  <= 1'b0;
          present_prev_q <= 1'b0;
          primed_q       <= 1'b0;
        end else begin
          cd_one_prev_q  <= pins_sync[`SDGC_LANE_CD_ONE];
          cd_two_prev_q  <= pins_sync[`SDGC_LANE_CD_TWO];
          present_prev_q <= card_present;
          primed_q       <= sync_valid;
        end
      end

      // Detect register storage; removal may return it to defaults
      always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          wake_en_q     <= 1'b0;
          removal_rst_q <= 1'b0;
        end else if (removal && removal_rst_q) begin
          wake_en_q     <= 1'b0;
          removal_rst_q <= 1'b0;
        end else if (det_wr) begin
          wake_en_q     <= reg_wdata[`SDGC_DET_WAKE_EN];
          removal_rst_q <= reg_wdata[`SDGC_DET_REMOVAL_RST];
        end
      end

      // Detect-change status flag; a set beats a clear
      always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          detect_flag_q <= 1'b0;
        end else if (flag_set) begin
          detect_flag_q <= 1'b1;
        end else if (flag_clr) begin
          detect_flag_q <= 1'b0;
        end
      end

      // Wake hold: set on a detect change, released when the flag clears
      always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          wake_low_q <= 1'b0;
        end else if (cd_change && wake_en_q) begin
          wake_low_q <= 1'b1;
        end else if (!detect_flag_q) begin
          wake_low_q <= 1'b0;
        end
      end

      // Removal with reset enabled asks for a compatibility reset
      assign compat_req[s] = removal & removal_rst_q;

      // Read images
      assign detect_rd_bus[s*8 +: 8] = {pins_sync[`SDGC_LANE_VS_TWO],
                                        pins_sync[`SDGC_LANE_VS_ONE],
                                        1'b0,
                                        wake_en_q,
                                        2'b00,
                                        removal_rst_q,
                                        1'b0};
      assign status_rd_bus[s*8 +: 8] = {7'h00, detect_flag_q};
      assign wake_low[s]             = wake_low_q;

      // Status-change host interrupt, gated by the detect enable
      sdgc_irq_gen u_sc_irq (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .level_mode (status_change_irq_level_sel),
        .pending    (detect_flag_q & card_detect_irq_enable[s]),
        .host_irq   (status_change_host_irq[s])
      );

      // Functional host interrupt, mode per socket
      assign func_level_sel = (s == 0) ? socket_a_irq_level_sel :
                                         socket_b_irq_level_sel;
      sdgc_irq_gen u_fn_irq (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .level_mode (func_level_sel),
        .pending    (~pins_sync[`SDGC_LANE_FUNC_IRQ] & primed_q),
        .host_irq   (func_host_irq[s])
      );

      // Card outputs float in sleep except during an active card cycle
      assign card_if_drive_en[s] = ~interface_sleep | card_cycle_active[s];
    end
  endgenerate

  // ----------------------------------------------------------------
  // DMA requests pass regardless of sleep
  // ----------------------------------------------------------------
  assign dma_request_out = dma_request;

  // ----------------------------------------------------------------
  // Compatibility reset pulse, one bit per socket
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      compat_reg_reset <= 2'b00;
    end else begin
      compat_reg_reset <= compat_req;
    end
  end

  // Ring indicate is low while either socket holds a wake
  assign ring_indicate_output_n = ~(|wake_low);

  // ----------------------------------------------------------------
  // Read data, registered on the read strobe
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (hit_detect) begin
        reg_rdata <= sel_b ? detect_rd_bus[15:8] : detect_rd_bus[7:0];
      end else if (hit_status) begin
        reg_rdata <= sel_b ? status_rd_bus[15:8] : status_rd_bus[7:0];
      end else if (hit_global) begin
        reg_rdata <= {3'b000, global_ctrl_q};
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

endmodule

// >>> pkg/sdgc_defs.vh
`ifndef SDGC_DEFS_VH
`define SDGC_DEFS_VH

// ----------------------------------------------------------------
// Register offsets (socket A; socket B adds the stride)
// ----------------------------------------------------------------
`define SDGC_OFS_STATUS_CHANGE   8'h04
`define SDGC_OFS_DETECT_GENERAL  8'h16
`define SDGC_OFS_GLOBAL_CONTROL  8'h1e
`define SDGC_SOCKET_B_STRIDE     8'h40

// ----------------------------------------------------------------
// Detect and general control fields
// ----------------------------------------------------------------
`define SDGC_DET_SENSE_TWO       7
`define SDGC_DET_SENSE_ONE       6
`define SDGC_DET_SOFT_IRQ        5
`define SDGC_DET_WAKE_EN         4
`define SDGC_DET_REMOVAL_RST     1
`define SDGC_DET_RESET           2'b00

// ----------------------------------------------------------------
// Global control fields
// ----------------------------------------------------------------
`define SDGC_GLB_B_LEVEL         4
`define SDGC_GLB_A_LEVEL         3
`define SDGC_GLB_CLEAR_METHOD    2
`define SDGC_GLB_SC_LEVEL        1
`define SDGC_GLB_SLEEP           0
`define SDGC_GLB_WIDTH           5
`define SDGC_GLB_RESET           5'h00

// ----------------------------------------------------------------
// Status change fields and synchroniser lanes
// ----------------------------------------------------------------
`define SDGC_STS_DETECT_CHANGE   0
`define SDGC_LANE_CD_ONE         0
`define SDGC_LANE_CD_TWO         1
`define SDGC_LANE_VS_ONE         2
`define SDGC_LANE_VS_TWO         3
`define SDGC_LANE_FUNC_IRQ       4
`define SDGC_LANES               5

`endif

// >>> testbench/sdgc_card_model.sv
`timescale 1ns/1ps

// ----------
// Two PC Cards as seen from the socket pins
// ----------
module sdgc_card_model (
  input  logic       sys_clk,
  input  logic [1:0] card_in,
  input  logic [1:0] irq_req,
  output logic [1:0] card_detect_one,
  output logic [1:0] card_detect_two,
  output logic [1:0] voltage_sense_one,
  output logic [1:0] voltage_sense_two,
  output logic [1:0] card_func_irq
);
  // Second detect contact seats one cycle after the first
  initial card_detect_two = 2'h3;
  always @(posedge sys_clk) card_detect_two <= ~card_in;
  // Seated card grounds detect and sense one; sense two stays pulled up
  assign card_detect_one   = ~card_in;
  assign voltage_sense_one = ~card_in;
  assign voltage_sense_two = 2'h3;
  assign card_func_irq     = ~(card_in & irq_req);  // Low while service wanted
endmodule

// >>> testbench/sdgc_top_checker.sv
`timescale 1ns/1ps

// ----------
// Port checker
// ----------
module sdgc_top_checker (
  input logic       sys_clk,
  input logic       reset_n,
  input logic [7:0] reg_addr,
  input logic       reg_wr,
  input logic       reg_rd,
  input logic [7:0] reg_wdata,
  input logic [7:0] reg_rdata,
  input logic [1:0] voltage_sense_one,
  input logic [1:0] voltage_sense_two,
  input logic [1:0] card_cycle_active,
  input logic [1:0] dma_request,
  input logic       ring_indicate_output_n,
  input logic [1:0] status_change_host_irq,
  input logic [1:0] func_host_irq,
  input logic [1:0] dma_request_out,
  input logic [1:0] card_if_drive_en,
  input logic [1:0] compat_reg_reset
);
  logic [4:0] glb_q;
  logic [1:0] rmv_q;
  logic [1:0] wake_q;
  wire        sts_acc = (reg_rd | reg_wr) && ((reg_addr & 8'hbf) == 8'h04);
  wire        glb_hit = (reg_addr & 8'hbf) == 8'h1e;
  wire        det_hit = (reg_addr & 8'hbf) == 8'h16;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Shadow of the writable control bits
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      glb_q  <= 5'h00;
      rmv_q  <= 2'h0;
      wake_q <= 2'h0;
    end else begin
      if (reg_wr && glb_hit) glb_q <= reg_wdata[4:0];
      for (int s = 0; s < 2; s++) begin
        if (compat_reg_reset[s]) begin
          rmv_q[s]  <= 1'b0;
          wake_q[s] <= 1'b0;
        end else if (reg_wr && det_hit && reg_addr[6] == s[0]) begin
          rmv_q[s]  <= reg_wdata[1];
          wake_q[s] <= reg_wdata[4];
        end
      end
    end
  end

  // Sense pins steady long enough to pass the synchroniser
  sequence sense_still;
    ($stable(voltage_sense_one[0]) && $stable(voltage_sense_two[0])) [*8];
  endsequence
  sequence det_a_read;
    reg_rd && reg_addr == 8'h16;
  endsequence

  chk_sense_live: assert property (sense_still ##0 det_a_read |=>
    reg_rdata[7:6] == {$past(voltage_sense_two[0]), $past(voltage_sense_one[0])})
    else $error("sense bits differ from pins");
  chk_det_zero: assert property (reg_rd && det_hit |=>
    reg_rdata[5] == 1'b0 && reg_rdata[3:2] == 2'h0 && reg_rdata[0] == 1'b0)
    else $error("detect register fixed bits not zero");
  chk_glb_shared: assert property (reg_rd && glb_hit |=>
    reg_rdata == {3'h0, glb_q}) else $error("global control readback wrong");
  chk_sleep_drive: assert property (
    card_if_drive_en == (glb_q[0] ? card_cycle_active : 2'h3))
    else $error("card drive enable wrong");
  chk_dma_pass: assert property (dma_request_out == dma_request)
    else $error("dma request not passed");
  chk_ring_release: assert property ($rose(ring_indicate_output_n) |->
    $past(sts_acc) || $past(sts_acc, 2) || $past(sts_acc, 3))
    else $error("ring released without status access");
  chk_ring_cause: assert property ($fell(ring_indicate_output_n) |->
    |$past(wake_q)) else $error("ring fell with wake disabled");
  chk_sc_pulse: assert property (
    status_change_host_irq[1] && !glb_q[1] && !reg_wr |=> !status_change_host_irq[1])
    else $error("status irq pulse too long");
  chk_func_a_pulse: assert property (
    func_host_irq[0] && !glb_q[3] && !reg_wr |=> !func_host_irq[0])
    else $error("socket a irq pulse too long");
  chk_func_b_pulse: assert property (
    func_host_irq[1] && !glb_q[4] && !reg_wr |=> !func_host_irq[1])
    else $error("socket b irq pulse too long");
  chk_compat_src: assert property (compat_reg_reset[0] |->
    rmv_q[0] ##1 !compat_reg_reset[0]) else $error("compat reset pulse wrong");
endmodule

bind sdgc_top sdgc_top_checker sdgc_top_checker_i (.*);

// >>> testbench/test_socket_detect_global_control.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("FAIL t=%0t got %0h exp %0h", $time, g, e); end end

// ----------
// Testbench
// ----------
module test_socket_detect_global_control;
  typedef struct {logic [7:0] a, w, r, e;} sdgc_row_t;
  logic       sys_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [1:0] card_in = 2'h0;
  logic [1:0] irq_req = 2'h0;
  logic [1:0] card_detect_irq_enable = 2'h0;
  logic [1:0] card_cycle_active = 2'h0;
  logic [1:0] dma_request = 2'h0;
  wire  [7:0] reg_rdata;
  wire  [1:0] card_detect_one, card_detect_two, voltage_sense_one, voltage_sense_two;
  wire  [1:0] card_func_irq, status_change_host_irq, func_host_irq, dma_request_out;
  wire  [1:0] card_if_drive_en, compat_reg_reset;
  wire        ring_indicate_output_n;
  wire  [5:0] pulse_v = {compat_reg_reset, func_host_irq, status_change_host_irq};
  logic [7:0] d;
  int         err_total = 0;
  int         checks_done = 0;
  int         cnt [6] = '{default: 0};
  int         b [6];
  sdgc_row_t  rows [8] = '{
    '{8'h1e, 8'hff, 8'h5e, 8'h1f}, '{8'h5e, 8'h0a, 8'h1e, 8'h0a},
    '{8'h1e, 8'h00, 8'h5e, 8'h00}, '{8'h16, 8'hff, 8'h16, 8'hd2},
    '{8'h56, 8'h12, 8'h56, 8'hd2}, '{8'h16, 8'h00, 8'h16, 8'hc0},
    '{8'h56, 8'h00, 8'h56, 8'hc0}, '{8'h20, 8'hff, 8'h20, 8'h00}};

  sdgc_top sdgc_top_i (.*);
  sdgc_card_model sdgc_card_model_i (.*);

  // Clock and output pulse counters
  initial forever #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    for (int k = 0; k < 6; k++) cnt[k] += (pulse_v[k] === 1'b1);
  end

  // Register port and wait helpers
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wait_ring(input logic v);
    for (int i = 0; i < 24 && ring_indicate_output_n !== v; i++) @(posedge sys_clk);
    #1;
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (3000) @(posedge sys_clk);
    err_total++;
    give_verdict();
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    tick(6);
    rd(8'h1e, d);
    `CHK(d, 8'h00)
    rd(8'h16, d);
    `CHK(d, 8'hc0)
    `CHK({ring_indicate_output_n, compat_reg_reset, card_if_drive_en}, 5'h13)
    $display("reset test done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].r, d);
      `CHK(d, rows[i].e)
    end
    $display("register table test done");
    @(posedge sys_clk);
    card_in <= 2'b01;
    tick(12);
    `CHK(ring_indicate_output_n, 1'b1)
    rd(8'h04, d);
    `CHK(d, 8'h01)
    rd(8'h04, d);
    `CHK(d, 8'h00)
    wr(8'h16, 8'h10);
    @(posedge sys_clk);
    card_in <= 2'b00;
    wait_ring(1'b0);
    `CHK(ring_indicate_output_n, 1'b0)
    wr(8'h1e, 8'h04);
    rd(8'h04, d);
    `CHK(d, 8'h01)
    tick(6);
    `CHK(ring_indicate_output_n, 1'b0)
    wr(8'h04, 8'h01);
    wait_ring(1'b1);
    `CHK(ring_indicate_output_n, 1'b1)
    `CHK(cnt[4], 0)
    wr(8'h16, 8'h00);
    $display("ring indicate test done");
    wr(8'h1e, 8'h06);
    @(posedge sys_clk);
    card_detect_irq_enable <= 2'b10;
    wr(8'h56, 8'h20);
    tick(8);
    `CHK(status_change_host_irq[1], 1'b1)
    wr(8'h44, 8'h01);
    tick(4);
    `CHK(status_change_host_irq[1], 1'b0)
    wr(8'h1e, 8'h04);
    b = cnt;
    wr(8'h56, 8'h20);
    tick(8);
    `CHK(cnt[1] - b[1], 1)
    wr(8'h44, 8'h01);
    @(posedge sys_clk);
    card_detect_irq_enable <= 2'b00;
    wr(8'h56, 8'h20);
    rd(8'h44, d);
    `CHK(d, 8'h00)
    $display("soft detect test done");
    @(posedge sys_clk);
    card_in <= 2'b11;
    tick(12);
    for (int s = 0; s < 2; s++) begin
      wr(8'h1e, s ? 8'h10 : 8'h08);
      @(posedge sys_clk);
      irq_req <= s ? 2'b10 : 2'b01;
      tick(8);
      `CHK(func_host_irq[s], 1'b1)
      @(posedge sys_clk);
      irq_req <= 2'b00;
      tick(8);
      `CHK(func_host_irq[s], 1'b0)
      wr(8'h1e, 8'h00);
      b = cnt;
      @(posedge sys_clk);
      irq_req <= s ? 2'b10 : 2'b01;
      tick(8);
      `CHK(cnt[2 + s] - b[2 + s], 1)
      @(posedge sys_clk);
      irq_req <= 2'b00;
      tick(4);
    end
    $display("function irq test done");
    wr(8'h1e, 8'h01);
    @(posedge sys_clk);
    card_cycle_active <= 2'b01;
    dma_request       <= 2'b10;
    tick(2);
    `CHK(card_if_drive_en, 2'b01)
    `CHK(dma_request_out, 2'b10)
    wr(8'h1e, 8'h00);
    tick(1);
    `CHK(card_if_drive_en, 2'b11)
    $display("sleep test done");
    wr(8'h16, 8'h02);
    b = cnt;
    @(posedge sys_clk);
    card_in <= 2'b10;
    tick(12);
    `CHK(cnt[4] - b[4], 1)
    rd(8'h16, d);
    `CHK(d, 8'hc0)
    $display("removal test done");
    wr(8'h5e, 8'h1f);
    tick(1);
    `CHK(card_if_drive_en, 2'b01)
    @(posedge sys_clk);
    reset_n <= 1'b0;
    tick(2);
    `CHK({ring_indicate_output_n, compat_reg_reset, card_if_drive_en}, 5'h13)
    @(posedge sys_clk);
    reset_n <= 1'b1;
    tick(6);
    rd(8'h5e, d);
    `CHK(d, 8'h00)
    rd(8'h56, d);
    `CHK(d, 8'h80)
    $display("mid-run reset test done");
    give_verdict();
  end
endmodule
